// ### hdl/cmfs_feature_select.v
// Control mode feature select: strap decode versus register fields
`timescale 1ns/100ps
`include "cmfs_defs.vh"

module cmfs_feature_select (
  input wire clock,
  input wire rst,
  input wire extended_mode,
  input wire reg_wr_en,
  input wire [3:0] reg_wr_addr,
  input wire [15:0] reg_wr_data,
  input wire [1:0] strap_data_rate,
  input wire strap_swing,
  input wire [1:0] strap_cal_dual_edge,
  input wire strap_fullscale,
  output reg ddr_mode,
  output reg ddr_clock_phase_select,
  output reg sdr_rising_edge,
  output reg output_swing_select,
  output reg cal_delay_long,
  output reg fullscale_normal,
  output reg [8:0] i_fullscale_trim,
  output reg [8:0] q_fullscale_trim,
  output reg offset_adjust_enable,
  output reg [8:0] i_offset_trim,
  output reg [8:0] q_offset_trim,
  output reg dual_edge_sampling_enable,
  output reg dual_edge_use_q,
  output reg test_pattern_output_enable,
  output reg resistor_trim_disable,
  output reg output_non_demux,
  output reg second_clock_enable,
  output reg phase_adjust_enable,
  output reg [8:0] sample_phase_coarse,
  output reg [7:0] sample_phase_fine
);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  wire [15:0] output_config;
  wire [15:0] i_offset_reg;
  wire [15:0] i_fullscale_reg;
  wire [15:0] extended_config;
  wire [15:0] q_offset_reg;
  wire [15:0] q_fullscale_reg;
  wire [15:0] phase_fine_reg;
  wire [15:0] phase_coarse_reg;

  // Writes only land in extended mode; the serial port is dead otherwise
  wire wr_gate = reg_wr_en & extended_mode;

  cmfs_reg_file u_regs (
    .clock(clock),
    .rst(rst),
    .wr_en(wr_gate),
    .wr_addr(reg_wr_addr),
    .wr_data(reg_wr_data),
    .output_config_q(output_config),
    .i_offset_trim_q(i_offset_reg),
    .i_fullscale_trim_q(i_fullscale_reg),
    .extended_config_q(extended_config),
    .q_offset_trim_q(q_offset_reg),
    .q_fullscale_trim_q(q_fullscale_reg),
    .sample_phase_fine_q(phase_fine_reg),
    .sample_phase_coarse_q(phase_coarse_reg)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [8:0] trim_field;
    input [15:0] r;
    begin
      trim_field = r[`CMFS_TRIM_MSB:`CMFS_TRIM_LSB];
    end
  endfunction

  function is_mid;
    input [1:0] lvl;
    begin
      is_mid = (lvl == `CMFS_LVL_MID);
    end
  endfunction

  // ----------------------------------------
  // Strap decode (non-extended)
  // ----------------------------------------
  // Data-rate strap: mid level means DDR, high or low means SDR with edge
  wire strap_ddr = is_mid(strap_data_rate);
  wire strap_edge_rise = (strap_data_rate == `CMFS_LVL_HIGH);
  wire strap_cal_long = (strap_cal_dual_edge == `CMFS_LVL_HIGH);
  wire strap_dual_edge = is_mid(strap_cal_dual_edge);

  // ----------------------------------------
  // Register field decode (extended)
  // ----------------------------------------
  wire reg_ddr = ~output_config[`CMFS_OC_SDR_DDR_N];
  wire reg_phase = output_config[`CMFS_OC_DDR_PHASE];
  wire reg_edge = output_config[`CMFS_OC_EDGE_DEMUX];
  wire reg_swing = output_config[`CMFS_OC_SWING];
  wire reg_second_clk_n = output_config[`CMFS_OC_SECOND_CLK_N];
  wire reg_dual_edge = extended_config[`CMFS_EC_DUAL_EDGE];
  wire reg_des_q = extended_config[`CMFS_EC_DES_Q_SEL];
  wire reg_test_pat = extended_config[`CMFS_EC_TEST_PAT];
  wire reg_trim_dis = extended_config[`CMFS_EC_TRIM_DIS];

  // ----------------------------------------
  // Source selection, registered outputs
  // ----------------------------------------
  // Mode is taken as static; a change mid-run just reselects sources
  // next cycle with no sequencing, so host must hold it fixed.
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ddr_mode <= 1'b1;
      ddr_clock_phase_select <= 1'b0;
      sdr_rising_edge <= 1'b0;
      output_swing_select <= 1'b1;
      cal_delay_long <= 1'b0;
      fullscale_normal <= 1'b1;
      i_fullscale_trim <= 9'h100;
      q_fullscale_trim <= 9'h100;
      offset_adjust_enable <= 1'b0;
      i_offset_trim <= 9'h000;
      q_offset_trim <= 9'h000;
      dual_edge_sampling_enable <= 1'b0;
      dual_edge_use_q <= 1'b0;
      test_pattern_output_enable <= 1'b0;
      resistor_trim_disable <= 1'b0;
      output_non_demux <= 1'b0;
      second_clock_enable <= 1'b0;
      phase_adjust_enable <= 1'b0;
      sample_phase_coarse <= 9'h000;
      sample_phase_fine <= 8'h00;
    end else if (extended_mode) begin
      ddr_mode <= reg_ddr;
      ddr_clock_phase_select <= reg_phase;
      sdr_rising_edge <= reg_edge;
      output_swing_select <= reg_swing;
      cal_delay_long <= 1'b0;
      fullscale_normal <= 1'b1;
      i_fullscale_trim <= trim_field(i_fullscale_reg);
      q_fullscale_trim <= trim_field(q_fullscale_reg);
      offset_adjust_enable <= 1'b1;
      i_offset_trim <= trim_field(i_offset_reg);
      q_offset_trim <= trim_field(q_offset_reg);
      dual_edge_sampling_enable <= reg_dual_edge;
      dual_edge_use_q <= reg_dual_edge & reg_des_q;
      test_pattern_output_enable <= reg_test_pat;
      resistor_trim_disable <= reg_trim_dis;
      output_non_demux <= reg_ddr & reg_edge;
      second_clock_enable <= ~reg_second_clk_n;
      phase_adjust_enable <= 1'b1;
      sample_phase_coarse <= trim_field(phase_coarse_reg);
      sample_phase_fine <= phase_fine_reg[`CMFS_FINE_MSB:`CMFS_FINE_LSB];
    end else begin
      ddr_mode <= strap_ddr;
      ddr_clock_phase_select <= 1'b0;
      sdr_rising_edge <= strap_edge_rise;
      output_swing_select <= strap_swing;
      cal_delay_long <= strap_cal_long;
      fullscale_normal <= strap_fullscale;
      i_fullscale_trim <= 9'h100;
      q_fullscale_trim <= 9'h100;
      offset_adjust_enable <= 1'b0;
      i_offset_trim <= 9'h000;
      q_offset_trim <= 9'h000;
      dual_edge_sampling_enable <= strap_dual_edge;
      dual_edge_use_q <= 1'b0;
      test_pattern_output_enable <= 1'b0;
      resistor_trim_disable <= 1'b0;
      output_non_demux <= 1'b0;
      second_clock_enable <= 1'b0;
      phase_adjust_enable <= 1'b0;
      sample_phase_coarse <= 9'h000;
      sample_phase_fine <= 8'h00;
    end
  end

endmodule // cmfs_feature_select

// ### hdl/cmfs_reg_file.v
// Write-only configuration register file, written by address and data
`timescale 1ns/100ps
`include "cmfs_defs.vh"

module cmfs_reg_file (
  input wire clock,
  input wire rst,
  input wire wr_en,
  input wire [3:0] wr_addr,
  input wire [15:0] wr_data,
  output reg [15:0] output_config_q,
  output reg [15:0] i_offset_trim_q,
  output reg [15:0] i_fullscale_trim_q,
  output reg [15:0] extended_config_q,
  output reg [15:0] q_offset_trim_q,
  output reg [15:0] q_fullscale_trim_q,
  output reg [15:0] sample_phase_fine_q,
  output reg [15:0] sample_phase_coarse_q
);

  // ----------------------------------------
  // Storage with power-on defaults
  // ----------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      output_config_q <= `CMFS_RST_OUTPUT_CONFIG;
      i_offset_trim_q <= `CMFS_RST_TRIM;
      i_fullscale_trim_q <= `CMFS_RST_TRIM;
      extended_config_q <= `CMFS_RST_EXTENDED_CONFIG;
      q_offset_trim_q <= `CMFS_RST_TRIM;
      q_fullscale_trim_q <= `CMFS_RST_TRIM;
      sample_phase_fine_q <= `CMFS_RST_PHASE_FINE;
      sample_phase_coarse_q <= `CMFS_RST_PHASE_COARSE;
    end else if (wr_en) begin
      // Unlisted and reserved addresses are dropped silently
      case (wr_addr)
        `CMFS_ADDR_OUTPUT_CONFIG: output_config_q <= wr_data;
        `CMFS_ADDR_I_OFFSET: i_offset_trim_q <= wr_data;
        `CMFS_ADDR_I_FULLSCALE: i_fullscale_trim_q <= wr_data;
        `CMFS_ADDR_EXTENDED_CONFIG: extended_config_q <= wr_data;
        `CMFS_ADDR_Q_OFFSET: q_offset_trim_q <= wr_data;
        `CMFS_ADDR_Q_FULLSCALE: q_fullscale_trim_q <= wr_data;
        `CMFS_ADDR_PHASE_FINE: sample_phase_fine_q <= wr_data;
        `CMFS_ADDR_PHASE_COARSE: sample_phase_coarse_q <= wr_data;
        default: output_config_q <= output_config_q;
      endcase
    end
  end

endmodule // cmfs_reg_file

// ### pkg/cmfs_defs.vh
// Constants for the control mode feature select block
`ifndef CMFS_DEFS_VH
`define CMFS_DEFS_VH

// ----------------------------------------
// Register addresses (4-bit serial address)
// ----------------------------------------
`define CMFS_ADDR_OUTPUT_CONFIG 4'h1
`define CMFS_ADDR_I_OFFSET 4'h2
`define CMFS_ADDR_I_FULLSCALE 4'h3
`define CMFS_ADDR_EXTENDED_CONFIG 4'h9
`define CMFS_ADDR_Q_OFFSET 4'hA
`define CMFS_ADDR_Q_FULLSCALE 4'hB
`define CMFS_ADDR_PHASE_FINE 4'hE
`define CMFS_ADDR_PHASE_COARSE 4'hF

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CMFS_OC_EDGE_DEMUX 8
`define CMFS_OC_SWING 9
`define CMFS_OC_SDR_DDR_N 10
`define CMFS_OC_DDR_PHASE 11
`define CMFS_OC_SECOND_CLK_N 13
`define CMFS_EC_DUAL_EDGE 13
`define CMFS_EC_TRIM_DIS 14
`define CMFS_EC_TEST_PAT 15
`define CMFS_EC_DES_Q_SEL 12
`define CMFS_TRIM_MSB 15
`define CMFS_TRIM_LSB 7
`define CMFS_FINE_MSB 15
`define CMFS_FINE_LSB 8

// ----------------------------------------
// Power-on reset values
// ----------------------------------------
`define CMFS_RST_OUTPUT_CONFIG 16'hB2FF
`define CMFS_RST_TRIM 16'h807F
`define CMFS_RST_EXTENDED_CONFIG 16'h03FF
`define CMFS_RST_PHASE_FINE 16'h00FF
`define CMFS_RST_PHASE_COARSE 16'h007F

// ----------------------------------------
// Strap tri-level codes
// ----------------------------------------
`define CMFS_LVL_LOW 2'h0
`define CMFS_LVL_HIGH 2'h1
`define CMFS_LVL_MID 2'h2

`endif

// ### tb/cmfs_chk.sv
// Port-level checker for the control mode feature select block
`timescale 1ns/100ps
module cmfs_chk (
  input wire clock,
  input wire rst,
  input wire extended_mode,
  input wire reg_wr_en,
  input wire [3:0] reg_wr_addr,
  input wire [15:0] reg_wr_data,
  input wire [1:0] strap_data_rate,
  input wire strap_swing,
  input wire [1:0] strap_cal_dual_edge,
  input wire strap_fullscale,
  input wire ddr_mode,
  input wire ddr_clock_phase_select,
  input wire output_swing_select,
  input wire cal_delay_long,
  input wire fullscale_normal,
  input wire [8:0] i_fullscale_trim,
  input wire offset_adjust_enable,
  input wire dual_edge_sampling_enable,
  input wire dual_edge_use_q,
  input wire test_pattern_output_enable,
  input wire resistor_trim_disable,
  input wire output_non_demux,
  input wire second_clock_enable,
  input wire phase_adjust_enable
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Write data two edges back, when the output shows it
  logic [15:0] d1_q, d2_q;
  wire wr = extended_mode && reg_wr_en;
  always @(posedge clock) begin
    d1_q <= reg_wr_data;
    d2_q <= d1_q;
  end
  a_strap_rate: assert property (
    !extended_mode |=> ddr_mode == ($past(strap_data_rate) == 2'h2) && !ddr_clock_phase_select)
    else $error("strap data rate decode wrong");
  a_cal_delay: assert property (
    1'b1 |=> cal_delay_long == (!$past(extended_mode) && $past(strap_cal_dual_edge) == 2'h1))
    else $error("calibration delay wrong");
  a_strap_level: assert property (
    !extended_mode |=> output_swing_select == $past(strap_swing)
      && fullscale_normal == $past(strap_fullscale)) else $error("strap level wrong");
  a_ext_only: assert property (
    !extended_mode |=> dual_edge_sampling_enable == ($past(strap_cal_dual_edge) == 2'h2)
      && !(dual_edge_use_q | test_pattern_output_enable | resistor_trim_disable
      | output_non_demux | second_clock_enable | offset_adjust_enable | phase_adjust_enable))
    else $error("extended feature active in strap mode");
  a_cfg_write: assert property (
    wr && reg_wr_addr == 4'h1 |-> ##2 ddr_mode == !d2_q[10] && ddr_clock_phase_select == d2_q[11]
      && output_swing_select == d2_q[9] && second_clock_enable == !d2_q[13]
      && output_non_demux == (!d2_q[10] && d2_q[8])) else $error("config write wrong");
  a_ext_write: assert property (
    wr && reg_wr_addr == 4'h9 |-> ##2 {test_pattern_output_enable, resistor_trim_disable,
      dual_edge_sampling_enable, dual_edge_use_q} == {d2_q[15:13], d2_q[13] & d2_q[12]})
    else $error("ext write wrong");
  a_trim_write: assert property (
    wr && reg_wr_addr == 4'h3 |-> ##2 i_fullscale_trim == d2_q[15:7])
    else $error("full-scale trim wrong");
  a_reset_dflt: assert property (disable iff (1'b0)
    rst |-> ddr_mode && output_swing_select && !(cal_delay_long | second_clock_enable
      | output_non_demux | test_pattern_output_enable | resistor_trim_disable
      | dual_edge_sampling_enable | ddr_clock_phase_select)) else $error("reset state wrong");
endmodule // cmfs_chk

// ### tb/cmfs_host.sv
// Host model driving the mode straps and register writes
`timescale 1ns/100ps
module cmfs_host (
  input wire clock,
  output logic extended_mode,
  output logic reg_wr_en,
  output logic [3:0] reg_wr_addr,
  output logic [15:0] reg_wr_data,
  output logic [1:0] strap_data_rate,
  output logic strap_swing,
  output logic [1:0] strap_cal_dual_edge,
  output logic strap_fullscale
);
  initial {extended_mode, reg_wr_en, reg_wr_addr, reg_wr_data} = '0;
  initial {strap_data_rate, strap_swing, strap_cal_dual_edge, strap_fullscale} = '0;
  // Caller holds reset while the mode moves
  task mode(input logic md);
    extended_mode <= md;
  endtask
  // Data inverted after the pulse so stale values never look valid
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(negedge clock);
    {reg_wr_en, reg_wr_addr, reg_wr_data} <= {1'b1, a, d};
    @(negedge clock);
    {reg_wr_en, reg_wr_data} <= {1'b0, ~d};
  endtask
  task pins(input logic [1:0] r, c, input logic s, f);
    @(negedge clock);
    {strap_data_rate, strap_cal_dual_edge, strap_swing, strap_fullscale} <= {r, c, s, f};
  endtask
endmodule // cmfs_host

// ### tb/test_control_mode_feature_select.sv
// Self-checking bench for the control mode feature select block
`timescale 1ns/100ps
`include "cmfs_defs.vh"
module test_control_mode_feature_select;
  logic clock = 1'b0;
  logic rst = 1'b0;
  logic m = 1'b1;
  logic [31:0] seed = 32'h0000754F;
  logic [15:0] live = 16'hCE0E;
  logic [15:0] regs [16];
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  wire extended_mode, reg_wr_en, strap_swing, strap_fullscale;
  wire [3:0] reg_wr_addr;
  wire [15:0] reg_wr_data;
  wire [1:0] strap_data_rate, strap_cal_dual_edge;
  wire ddr_mode, ddr_clock_phase_select, sdr_rising_edge, output_swing_select, cal_delay_long;
  wire fullscale_normal, offset_adjust_enable, dual_edge_sampling_enable, dual_edge_use_q;
  wire test_pattern_output_enable, resistor_trim_disable, output_non_demux;
  wire second_clock_enable, phase_adjust_enable;
  wire [8:0] i_fullscale_trim, q_fullscale_trim, i_offset_trim, q_offset_trim;
  wire [8:0] sample_phase_coarse;
  wire [7:0] sample_phase_fine;
  cmfs_host host (.*);
  cmfs_feature_select uut (.*);
  always #20 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      close_out();
    end
  end
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input string n, input logic [15:0] s, e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task rs(input logic md);
    @(negedge clock);
    rst <= 1'b1;
    host.mode(md);
    m = md;
    foreach (regs[i]) regs[i] = `CMFS_RST_TRIM;
    regs[1] = `CMFS_RST_OUTPUT_CONFIG;
    regs[9] = `CMFS_RST_EXTENDED_CONFIG;
    regs[14] = `CMFS_RST_PHASE_FINE;
    regs[15] = `CMFS_RST_PHASE_COARSE;
    repeat (8) @(negedge clock);
    rst <= 1'b0;
  endtask
  task w(input logic [3:0] a, input logic [15:0] d);
    host.wr(a, d);
    if (m && live[a]) regs[a] = d;
  endtask
  task cmp();
    logic [15:0] oc, ec;
    repeat (3) @(negedge clock);
    oc = regs[1];
    ec = regs[9];
    chk("ddr_mode", ddr_mode, m ? !oc[10] : strap_data_rate == 2'h2);
    chk("ddr_phase", ddr_clock_phase_select, m & oc[11]);
    if (m || strap_data_rate != 2'h2)
      chk("sdr_edge", sdr_rising_edge, m ? oc[8] : strap_data_rate == 2'h1);
    chk("swing", output_swing_select, m ? oc[9] : strap_swing);
    chk("cal_long", cal_delay_long, !m && strap_cal_dual_edge == 2'h1);
    chk("fs_normal", fullscale_normal, m | strap_fullscale);
    chk("offset_en", offset_adjust_enable, m);
    chk("dual_edge", dual_edge_sampling_enable, m ? ec[13] : strap_cal_dual_edge == 2'h2);
    chk("use_q", dual_edge_use_q, m & ec[13] & ec[12]);
    chk("pattern", test_pattern_output_enable, m & ec[15]);
    chk("trim_dis", resistor_trim_disable, m & ec[14]);
    chk("non_demux", output_non_demux, m & !oc[10] & oc[8]);
    chk("second_clk", second_clock_enable, m & !oc[13]);
    chk("phase_en", phase_adjust_enable, m);
    if (m) begin
      chk("i_fs", i_fullscale_trim, regs[3][15:7]);
      chk("q_fs", q_fullscale_trim, regs[11][15:7]);
      chk("i_off", i_offset_trim, regs[2][15:7]);
      chk("q_off", q_offset_trim, regs[10][15:7]);
      chk("coarse", sample_phase_coarse, regs[15][15:7]);
      chk("fine", sample_phase_fine, regs[14][15:8]);
    end
  endtask
  initial begin
    logic [31:0] r;
    rs(1'b1);
    cmp();
    $display("test reset_defaults done");
    repeat (60) begin
      r = xs();
      w(r[8] ? 4'h1 : r[3:0], r[31:16]);
      host.pins({1'b0, r[4]}, {r[5], 1'b0}, r[6], r[7]);
      cmp();
    end
    $display("test extended_writes done");
    rs(1'b1);
    cmp();
    $display("test second_reset done");
    rs(1'b0);
    for (int i = 0; i < 18; i++) begin
      r = xs();
      w(r[3:0], r[31:16]);
      host.pins(2'((i % 9) / 3), 2'(i % 3), r[6], r[7]);
      cmp();
    end
    $display("test strap_mode done");
    close_out();
  end
endmodule // test_control_mode_feature_select
bind cmfs_feature_select cmfs_chk chk (.*);
